// ==== sysref_capture_control.sv ====
// sysref capture control: registers, edge selection, n-shot and skew window checks
//
// Contract
// [RL1] flag reset bit holds error flags cleared
// [RL2] transition select picks rising or falling sysref
// [RL3] host disables capture before changing transition select
// [RL4] edge select picks rising or falling clock
// [RL5] mode: 0 off, 1 continuous, 2 n-shot
// [RL6] n-shot skips the programmed number of transitions
// [RL7] negative window codes 0 and 1 tolerance
// [RL8] negative window codes 2 and 3 tolerance
// [RL9] positive window gives zero to three cycles
// [RL10] n-shot acts once until software re-arms
`timescale 1ns/1ps
`default_nettype none
module sysref_capture_control
   import sysref_cap_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic        sysref_in,
   input  wire logic [11:0] reg_addr,
   input  wire logic        reg_we,
   input  wire logic        reg_re,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   output logic             capture_pulse,
   output logic             realign_pulse,
   output logic             setup_err,
   output logic             hold_err,
   output logic             nshot_done,
   output logic      [3:0]  frame_phase
);

   cap_state_t        st_r;            // registered state
   cap_state_t        st_nxt;          // next state
   logic              rise_q;          // sysref sampled on rising clock
   logic              fall_q;          // sysref sampled on falling clock
   logic              smp;             // sysref on the selected clock edge
   logic              valid_tr;        // valid transition this cycle
   logic              act;             // transition acted on this cycle
   logic [3:0]        early_d;         // cycles before the frame boundary

   ////////////////////////////////////////////////////////////////////////////////
   // synchronisers for both clock edges
   sysref_sampler #(.FALL(1'b0)) u_rise_smp
   (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .pin_in  (sysref_in),
      .q       (rise_q)
   );

   sysref_sampler #(.FALL(1'b1)) u_fall_smp
   (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .pin_in  (sysref_in),
      .q       (fall_q)
   );

   // pick the sampling edge
   assign smp      = st_r.ctrl.edge_sel ? fall_q : rise_q;  // RL4
   // pick the valid transition direction
   assign valid_tr = st_r.ctrl.trans_sel ? (st_r.smp_prev & ~smp)
                                         : (smp & ~st_r.smp_prev);  // RL2
   assign early_d  = 4'h0 - st_r.phase;

   ////////////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb
   begin
      st_nxt           = st_r;
      act              = 1'b0;
      st_nxt.cap_pulse = 1'b0;
      st_nxt.realign   = 1'b0;
      st_nxt.smp_prev  = smp;
      st_nxt.phase     = st_r.phase + 4'h1;

      // capture decision per mode
      case (cap_mode_t'(st_r.ctrl.mode))  // RL5
         MODE_CONT:
            act = valid_tr;
         MODE_NSHOT:
         begin
            if (valid_tr && !st_r.done)  // RL10
            begin
               if (st_r.seen < st_r.ctrl.ign)
                  st_nxt.seen = st_r.seen + 4'h1;  // RL6
               else
               begin
                  act         = 1'b1;
                  st_nxt.done = 1'b1;  // RL10
               end
            end
         end
         default:
            act = 1'b0;
      endcase

      // skew window check of an acted transition
      if (act)
      begin
         st_nxt.cap_pulse = 1'b1;
         if (st_r.phase == 4'h0)
            st_nxt.realign = 1'b0;  // RL7
         else if (st_r.phase <= {2'b00, st_r.ctrl.pos_win})
            st_nxt.realign = 1'b0;  // RL9
         else if (early_d <= {2'b00, st_r.ctrl.neg_win})
            st_nxt.realign = 1'b0;  // RL8
         else
         begin
            st_nxt.realign = 1'b1;
            st_nxt.phase   = 4'h0;
            if (st_r.phase < PHASE_HALF)
               st_nxt.hold_err = 1'b1;
            else
               st_nxt.setup_err = 1'b1;
         end
      end

      // flag reset overrides any new error
      if (st_r.ctrl.flag_rst)
      begin
         st_nxt.setup_err = 1'b0;  // RL1
         st_nxt.hold_err  = 1'b0;  // RL1
      end

      // register writes; a control write re-arms n-shot
      if (reg_we)
      begin
         case (reg_addr)
            ADDR_CAPTURE_CONTROL:
            begin
               st_nxt.ctrl.flag_rst  = reg_wdata[FLAG_RST_BIT];
               st_nxt.ctrl.trans_sel = reg_wdata[TRANS_SEL_BIT];
               st_nxt.ctrl.edge_sel  = reg_wdata[EDGE_SEL_BIT];
               st_nxt.ctrl.mode      = reg_wdata[MODE_LSB +: 2];
               st_nxt.seen           = 4'h0;
               st_nxt.done           = 1'b0;
            end
            ADDR_IGNORE_COUNT:
               st_nxt.ctrl.ign = reg_wdata[IGN_LSB +: 4];
            ADDR_SKEW_WINDOW:
            begin
               st_nxt.ctrl.neg_win = reg_wdata[NEG_WIN_LSB +: 2];
               st_nxt.ctrl.pos_win = reg_wdata[POS_WIN_LSB +: 2];
            end
            default:
               st_nxt.seen = st_nxt.seen;
         endcase
      end

      // register reads, reserved bits as zero
      if (reg_re)
      begin
         st_nxt.rdata = RDATA_UNMAPPED;
         case (reg_addr)
            ADDR_CAPTURE_CONTROL:
            begin
               st_nxt.rdata[FLAG_RST_BIT]   = st_r.ctrl.flag_rst;
               st_nxt.rdata[TRANS_SEL_BIT]  = st_r.ctrl.trans_sel;
               st_nxt.rdata[EDGE_SEL_BIT]   = st_r.ctrl.edge_sel;
               st_nxt.rdata[MODE_LSB +: 2]  = st_r.ctrl.mode;
            end
            ADDR_IGNORE_COUNT:
               st_nxt.rdata[IGN_LSB +: 4] = st_r.ctrl.ign;
            ADDR_SKEW_WINDOW:
            begin
               st_nxt.rdata[NEG_WIN_LSB +: 2] = st_r.ctrl.neg_win;
               st_nxt.rdata[POS_WIN_LSB +: 2] = st_r.ctrl.pos_win;
            end
            default:
               st_nxt.rdata = RDATA_UNMAPPED;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_r              <= '0;
         st_r.ctrl.flag_rst  <= RST_CAPTURE_CONTROL[FLAG_RST_BIT];
         st_r.ctrl.trans_sel <= RST_CAPTURE_CONTROL[TRANS_SEL_BIT];
         st_r.ctrl.edge_sel  <= RST_CAPTURE_CONTROL[EDGE_SEL_BIT];
         st_r.ctrl.mode      <= RST_CAPTURE_CONTROL[MODE_LSB +: 2];
         st_r.ctrl.ign       <= RST_IGNORE_COUNT[IGN_LSB +: 4];
         st_r.ctrl.neg_win   <= RST_SKEW_WINDOW[NEG_WIN_LSB +: 2];
         st_r.ctrl.pos_win   <= RST_SKEW_WINDOW[POS_WIN_LSB +: 2];
      end
      else
         st_r <= st_nxt;
   end

   // outputs straight from the state register
   assign reg_rdata     = st_r.rdata;
   assign capture_pulse = st_r.cap_pulse;
   assign realign_pulse = st_r.realign;
   assign setup_err     = st_r.setup_err;
   assign hold_err      = st_r.hold_err;
   assign nshot_done    = st_r.done;
   assign frame_phase   = st_r.phase;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   // a transition reaching the checker with a given mode
   sequence s_cont_rise;
      st_r.ctrl.mode == 2'h1 && !st_r.ctrl.trans_sel && $rose(smp);
   endsequence

   sequence s_cont_fall;
      st_r.ctrl.mode == 2'h1 && st_r.ctrl.trans_sel && $fell(smp);
   endsequence

   flag_hold_clear_a: // RL1
      assert property (st_r.ctrl.flag_rst && !reg_we |=> !setup_err && !hold_err)
      else $error("error flag set while flag reset held");

   rise_select_a: // RL2
      assert property (s_cont_rise |=> capture_pulse)
      else $error("rising sysref not captured");

   fall_select_a: // RL2
      assert property (s_cont_fall |=> capture_pulse)
      else $error("falling sysref not captured");

   fall_edge_a: // RL4
      assert property (st_r.ctrl.edge_sel && $rose(fall_q) && $stable(st_r.ctrl.edge_sel)
                       |-> $rose(smp))
      else $error("falling clock sample not selected");

   mode_off_a: // RL5
      assert property (st_r.ctrl.mode == 2'h0 || st_r.ctrl.mode == 2'h3 |=> !capture_pulse)
      else $error("capture while disabled");

   nshot_skip_a: // RL6
      assert property (st_r.ctrl.mode == 2'h2 && valid_tr && !st_r.done && !reg_we
                       && st_r.seen < st_r.ctrl.ign
                       |=> !capture_pulse && st_r.seen == $past(st_r.seen) + 4'h1)
      else $error("n-shot did not skip transition");

   nshot_once_a: // RL10
      assert property (st_r.ctrl.mode == 2'h2 && st_r.done |=> !capture_pulse)
      else $error("n-shot acted twice");

   neg_window_a: // RL8
      assert property (act && st_r.phase != 4'h0
                       && early_d <= {2'b00, st_r.ctrl.neg_win} |=> !realign_pulse)
      else $error("early transition inside window realigned");

   pos_window_a: // RL9
      assert property (act && st_r.phase <= {2'b00, st_r.ctrl.pos_win}
                       |=> !realign_pulse)
      else $error("late transition inside window realigned");

   late_miss_a: // RL7
      assert property (act && st_r.phase > {2'b00, st_r.ctrl.pos_win}
                       && st_r.phase < PHASE_HALF && !st_r.ctrl.flag_rst
                       && early_d > {2'b00, st_r.ctrl.neg_win}
                       |=> realign_pulse && hold_err ##1 frame_phase == 4'h1)
      else $error("late transition outside window not flagged");

endmodule
`default_nettype wire

// ==== sysref_cap_pkg.sv ====
// shared constants, modes and state carriers for the sysref capture control block
package sysref_cap_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // register offsets on the serial-port register path
   localparam logic [11:0] ADDR_CAPTURE_CONTROL = 12'h120;  // sysref_capture_control
   localparam logic [11:0] ADDR_IGNORE_COUNT    = 12'h121;  // sysref_ignore_count
   localparam logic [11:0] ADDR_SKEW_WINDOW     = 12'h122;  // sysref_skew_window

   // reset values of the three registers
   localparam logic [7:0]  RST_CAPTURE_CONTROL  = 8'h00;
   localparam logic [7:0]  RST_IGNORE_COUNT     = 8'h00;
   localparam logic [7:0]  RST_SKEW_WINDOW      = 8'h00;
   localparam logic [7:0]  RDATA_UNMAPPED       = 8'h00;    // answer for unmapped reads

   ////////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int FLAG_RST_BIT  = 6;                         // flag reset bit
   localparam int TRANS_SEL_BIT = 4;                         // transition select bit
   localparam int EDGE_SEL_BIT  = 3;                         // clock edge select bit
   localparam int MODE_LSB      = 1;                         // capture mode [2:1]
   localparam int IGN_LSB       = 0;                         // ignore count [3:0]
   localparam int NEG_WIN_LSB   = 2;                         // negative window [3:2]
   localparam int POS_WIN_LSB   = 0;                         // positive window [1:0]

   ////////////////////////////////////////////////////////////////////////////////
   // local frame phase counter: wraps naturally at 16 cycles
   localparam int          PHASE_W    = 4;
   localparam logic [3:0]  PHASE_HALF = 4'h8;               // below: late, else early

   ////////////////////////////////////////////////////////////////////////////////
   // capture modes, encoded 0, 1, 2 in declaration order
   typedef enum logic [1:0] {
      MODE_OFF,
      MODE_CONT,
      MODE_NSHOT
   } cap_mode_t;

   // software control fields
   typedef struct packed {
      logic        flag_rst;     // hold setup and hold flags cleared
      logic        trans_sel;    // 0 rising sysref, 1 falling sysref
      logic        edge_sel;     // 0 rising clock, 1 falling clock
      logic [1:0]  mode;         // capture mode code
      logic [3:0]  ign;          // n-shot transitions to skip
      logic [1:0]  neg_win;      // early tolerance in cycles
      logic [1:0]  pos_win;      // late tolerance in cycles
   } cap_ctrl_t;

   // whole state of the capture block
   typedef struct packed {
      cap_ctrl_t             ctrl;       // register contents
      logic                  smp_prev;   // sysref level one cycle ago
      logic [3:0]            seen;       // n-shot transitions skipped so far
      logic                  done;       // n-shot has acted
      logic [PHASE_W-1:0]    phase;      // local frame phase
      logic                  setup_err;  // early beyond window
      logic                  hold_err;   // late beyond window
      logic                  cap_pulse;  // transition acted on
      logic                  realign;    // phase was realigned
      logic [7:0]            rdata;      // read data register
   } cap_state_t;

endpackage

// ==== sysref_sampler.sv ====
// two-stage synchroniser for the sysref pin, first stage on a chosen clock edge
`timescale 1ns/1ps
`default_nettype none
module sysref_sampler
#(
   parameter bit FALL = 1'b0           // first stage on falling clock edge
)
(
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   input  wire logic pin_in,
   output logic      q
);

   logic stage1_r;                      // read only by the second stage

   ////////////////////////////////////////////////////////////////////////////////
   // first stage on the selected edge
   generate
      if (FALL)
      begin : g_fall
         always_ff @(negedge ref_clk or posedge sys_rst)
         begin
            if (sys_rst)
               stage1_r <= 1'b0;
            else
               stage1_r <= pin_in;
         end
      end
      else
      begin : g_rise
         always_ff @(posedge ref_clk or posedge sys_rst)
         begin
            if (sys_rst)
               stage1_r <= 1'b0;
            else
               stage1_r <= pin_in;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // second stage always on the rising edge
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         q <= 1'b0;
      else
         q <= stage1_r;
   end

endmodule
`default_nettype wire

// ==== sysref_source.sv ====
// model of the sysref timing source: one four-cycle high pulse per fire request
`timescale 1ns/1ps
`default_nettype none
module sysref_source
(
   input  wire logic ref_clk,
   input  wire logic fire,
   output logic      sysref
);
   logic [2:0] left_r = 3'h0;   // cycles of pulse still to send

   ////////////////////////////////////////////////////////////////////////////////
   // load the pulse length on fire, count it down; the pin idles low between pulses
   always @(posedge ref_clk)
   begin
      if (fire)
         left_r <= 3'h4;
      else if (left_r != 3'h0)
         left_r <= left_r - 3'h1;
   end

   // pin is high while the pulse lasts, so each pulse has one rise and one fall
   assign sysref = (left_r != 3'h0);
endmodule
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the sysref capture control block
`timescale 1ns/1ps
`default_nettype none
module testbench
   import sysref_cap_pkg::*;
;
   logic        ref_clk;         // sample clock
   logic        sys_rst;         // asynchronous reset
   logic        fire;            // asks the source for one pulse
   logic        sysref_in;       // sysref pin from the source
   logic [11:0] reg_addr;        // register address
   logic        reg_we;          // write strobe
   logic        reg_re;          // read strobe
   logic [7:0]  reg_wdata;       // write data
   logic [7:0]  reg_rdata;       // read data
   logic        capture_pulse;   // transition acted on
   logic        realign_pulse;   // phase realigned
   logic        setup_err;       // early error flag
   logic        hold_err;        // late error flag
   logic        nshot_done;      // n-shot has acted
   logic [3:0]  frame_phase;     // local frame phase
   int          n_mismatch;      // mismatches seen
   int          checks_done;     // comparisons made
   int          cnt;             // captures in one shot
   int          lat;             // cycles from fire to capture
   int          i;
   int          j;
   int          n;
   logic        rl;              // realign seen with the capture
   logic [7:0]  rv;              // read value
   logic [7:0]  rmask [3];       // readable bits per register
   logic [14:0] rows [12];       // phase, window byte, {realign, hold, setup}

   ////////////////////////////////////////////////////////////////////////////////
   // design and sysref source
   sysref_capture_control DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .sysref_in(sysref_in),
      .reg_addr(reg_addr), .reg_we(reg_we), .reg_re(reg_re), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .capture_pulse(capture_pulse), .realign_pulse(realign_pulse),
      .setup_err(setup_err), .hold_err(hold_err), .nshot_done(nshot_done),
      .frame_phase(frame_phase));
   sysref_source SRC (.ref_clk(ref_clk), .fire(fire), .sysref(sysref_in));

   // 50 ns clock
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // compare and report at once
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // one register write, strobe held over one rising edge
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      reg_addr  = a;
      reg_wdata = d;
      reg_we    = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_we = 1'b0;
   endtask

   // one register read; data is taken once it has surely landed
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      reg_re   = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_re = 1'b0;
      @(posedge ref_clk);
      #1;
      d = reg_rdata;
   endtask

   // wait until the decision phase will be p, fire a pulse, watch fourteen cycles
   task automatic shot(input logic [3:0] p, output int c, output int l, output logic r);
      logic [3:0] kk;
      int         k;
      kk = p - 4'h3;
      c  = 0;
      l  = 0;
      r  = 1'b0;
      for (k = 0; k < 20 && frame_phase !== kk; k++)
      begin
         @(posedge ref_clk);
         #1;
      end
      fire = 1'b1;
      for (k = 1; k <= 14; k++)
      begin
         @(posedge ref_clk);
         #1;
         if (k == 1)
            fire = 1'b0;
         if (capture_pulse === 1'b1)
         begin
            c++;
            l = k;
            r = realign_pulse;
         end
      end
   endtask

   // counts, verdict and end of run
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // hang guard, about eight times the expected run
   initial
   begin
      #400000;
      n_mismatch++;
      $display("BAD %0t watchdog expired", $time);
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      sys_rst     = 1'b1;
      fire        = 1'b0;
      reg_addr    = 12'h000;
      reg_we      = 1'b0;
      reg_re      = 1'b0;
      reg_wdata   = 8'h00;
      n_mismatch  = 0;
      checks_done = 0;
      rmask = '{8'h5E, 8'h0F, 8'h0F};
      rows = '{{4'h0, 8'h00, 3'b000}, {4'h1, 8'h00, 3'b110}, {4'h1, 8'h01, 3'b000},
               {4'h3, 8'h03, 3'b000}, {4'h4, 8'h03, 3'b110}, {4'hF, 8'h00, 3'b101},
               {4'hF, 8'h04, 3'b000}, {4'hE, 8'h04, 3'b101}, {4'hE, 8'h08, 3'b000},
               {4'hD, 8'h0C, 3'b000}, {4'hD, 8'h08, 3'b101}, {4'h8, 8'h0F, 3'b101}};
      repeat (12) @(posedge ref_clk);
      #1;
      sys_rst = 1'b0;
      // reset values, then reserved bits reading zero
      for (i = 0; i < 3; i++)
      begin
         rd(ADDR_CAPTURE_CONTROL + 12'(i), rv);
         chk(rv, (i == 0) ? RST_CAPTURE_CONTROL
                          : ((i == 1) ? RST_IGNORE_COUNT : RST_SKEW_WINDOW), "reset value");
         wr(ADDR_CAPTURE_CONTROL + 12'(i), 8'hFF);
         rd(ADDR_CAPTURE_CONTROL + 12'(i), rv);
         chk(rv, rmask[i], "readable bits");
      end
      // unmapped place ignores writes and reads zero
      wr(12'h123, 8'hFF);
      rd(12'h123, rv);
      chk(rv, RDATA_UNMAPPED, "unmapped read");
      // disable capture before the polarity goes back to rising
      wr(ADDR_CAPTURE_CONTROL, 8'h10);
      // window table in continuous mode, flags cleared before each row
      for (i = 0; i < 12; i++)
      begin
         wr(ADDR_SKEW_WINDOW, rows[i][10:3]);
         wr(ADDR_CAPTURE_CONTROL, 8'h40);
         wr(ADDR_CAPTURE_CONTROL, 8'h02);
         shot(rows[i][14:11], cnt, lat, rl);
         chk(8'(cnt), 8'h01, "capture count");
         chk(8'(lat), 8'h04, "rising clock latency");
         chk({5'h00, rl, hold_err, setup_err}, {5'h00, rows[i][2:0]}, "window");
      end
      // flags held clear while the flag reset bit is set
      wr(ADDR_SKEW_WINDOW, 8'h00);
      wr(ADDR_CAPTURE_CONTROL, 8'h42);
      shot(4'h4, cnt, lat, rl);
      chk({5'h00, rl, hold_err, setup_err}, 8'h04, "flags held clear");
      // realign zeroed the phase at the capture, ten edges before the end of the shot
      chk({4'h0, frame_phase}, 8'h0A, "phase after realign");
      // disabled and undefined mode act on nothing
      for (i = 0; i < 2; i++)
      begin
         wr(ADDR_CAPTURE_CONTROL, (i == 0) ? 8'h00 : 8'h06);
         shot(4'h0, cnt, lat, rl);
         chk(8'(cnt), 8'h00, "disabled capture");
      end
      // falling clock edge samples half a cycle sooner
      wr(ADDR_CAPTURE_CONTROL, 8'h0A);
      shot(4'h0, cnt, lat, rl);
      chk(8'(cnt), 8'h01, "falling clock count");
      chk(8'(lat), 8'h03, "falling clock latency");
      // falling sysref selected with capture off, then enabled
      wr(ADDR_CAPTURE_CONTROL, 8'h00);
      wr(ADDR_CAPTURE_CONTROL, 8'h10);
      wr(ADDR_CAPTURE_CONTROL, 8'h12);
      shot(4'h0, cnt, lat, rl);
      chk(8'(cnt), 8'h01, "falling sysref count");
      chk(8'(lat), 8'h08, "falling sysref latency");
      wr(ADDR_CAPTURE_CONTROL, 8'h10);
      wr(ADDR_CAPTURE_CONTROL, 8'h00);
      // n-shot with ignore counts 0, 2 and 15, re-armed by each control write
      for (j = 0; j < 3; j++)
      begin
         n = (j == 0) ? 0 : ((j == 1) ? 2 : 15);
         wr(ADDR_IGNORE_COUNT, 8'(n));
         wr(ADDR_CAPTURE_CONTROL, 8'h04);
         chk({7'h00, nshot_done}, 8'h00, "re-armed");
         for (i = 0; i <= n + 1; i++)
         begin
            shot(4'h0, cnt, lat, rl);
            chk(8'(cnt), (i == n) ? 8'h01 : 8'h00, "n-shot count");
         end
         chk({7'h00, nshot_done}, 8'h01, "n-shot done");
      end
      // reset in mid-run clears flags, n-shot state and registers, phase restarts
      wr(ADDR_SKEW_WINDOW, 8'h0F);
      @(posedge ref_clk);
      #1;
      sys_rst = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      sys_rst = 1'b0;
      chk({5'h00, nshot_done, hold_err, setup_err}, 8'h00, "flags after reset");
      @(posedge ref_clk);
      #1;
      chk({4'h0, frame_phase}, 8'h01, "phase after reset");
      rd(ADDR_SKEW_WINDOW, rv);
      chk(rv, RST_SKEW_WINDOW, "window after reset");
      close_out();
   end
endmodule
`default_nettype wire
